// *** logic/secm_pkg.sv ***
/*
  secm_pkg: register map, field layout, reset values and carrier types
  of the error capture and error rate monitor.
  assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
*/
package secm_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LT_DETECT = 8'h00;
  localparam logic [7:0] OFS_LT_ENABLE = 8'h04;
  localparam logic [7:0] OFS_LT_ADDR = 8'h08;
  localparam logic [7:0] OFS_LT_DEVID = 8'h0C;
  localparam logic [7:0] OFS_LT_CTRL = 8'h10;
  localparam logic [7:0] OFS_PW_TARGET = 8'h14;
  localparam logic [7:0] OFS_PORT_DETECT = 8'h18;
  localparam logic [7:0] OFS_RATE_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_CAPT_ATTR = 8'h20;
  localparam logic [7:0] OFS_CAPT0 = 8'h24;
  localparam logic [7:0] OFS_CAPT1 = 8'h28;
  localparam logic [7:0] OFS_CAPT2 = 8'h2C;
  localparam logic [7:0] OFS_CAPT3 = 8'h30;
  localparam logic [7:0] OFS_ERR_RATE = 8'h34;
  localparam logic [7:0] OFS_THRESHOLD = 8'h38;
  localparam logic [7:0] OFS_DEBUG_CTRL = 8'h3C;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CAPT_WORDS = 4;
  localparam int ATTR_VALID_BIT = 0;
  localparam int ATTR_TYPE_LSB = 24;
  localparam int ATTR_INFO_BIT = 30;
  localparam int CTRL_FTYPE_LSB = 28;
  localparam int CTRL_TTYPE_LSB = 24;
  localparam int DEBUG_MODE_BIT = 0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] RATE_MAX = 8'hFF;
  localparam logic [7:0] RATE_ONE = 8'h01;
  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam logic [7:0] HOP_ZERO = 8'h00;
  localparam logic [15:0] PW_TARGET_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SECM_BUS_IDLE = 2'b01,
    SECM_BUS_ACK = 2'b10
  } secm_bus_e;
  typedef enum logic [1:0] {
    SECM_PKT_MREQ = 2'h0,
    SECM_PKT_MRSP = 2'h1,
    SECM_PKT_PWRITE = 2'h2,
    SECM_PKT_OTHER = 2'h3
  } secm_pkt_e;
  // logical/transport error event from the packet checker
  typedef struct packed {
    logic valid;
    secm_pkt_e kind;
    logic [7:0] hop_count;
    logic tt_bad;
    logic well_formed;
    logic [31:0] err_bits;
    logic [31:0] addr_field;
    logic [31:0] devid_field;
    logic [63:0] hdr_bytes;
    logic [3:0] ftype;
    logic [3:0] ttype;
  } secm_lt_evt_s;
  // transmission error event from the port
  typedef struct packed {
    logic [31:0] err_bits;
    logic is_symbol;
    logic [127:0] capt_words;
  } secm_tx_evt_s;
endpackage

// *** logic/secm_monitor.sv ***
/*
  secm_monitor: logical/transport error capture, port-write target,
  port transmission error detect/capture and error rate threshold.
  assumes synchronous inputs on core_clk_i and an avalon-mm master
  that holds its request until waitrequest is sampled low.
*/
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
// Behaviour
// - lt capture registers freeze once an enabled lt error is logged
// - only hop-zero maintenance requests, responses, port-writes are checked
// - address capture is meaningful only for malformed maintenance requests
// - invalid tt code still loads address capture from the address position
// - correctly formatted failing requests leave address, devid, control capture
// - undefined tt makes devid capture hold received bytes 3 and 4
// - control capture records ftype and the four following bits as ttype
// - port-writes go to programmed target via the lut-selected port
// - nonzero detect write bumps the rate counter when enabled
// - reaching the threshold reports the error to software
// - only enabled errors count and get captured
// - simultaneous errors encode exactly one error type
// - while capture valid is set other attribute fields are read-only
// - debug mode unlocks every attribute field for writing
// - debug mode makes first capture word writable, packet bytes 4..7
// - normally first capture word takes bytes 0..3 or the whole symbol
// - detect and capture registers are software writable for testing
// - powered-down port: registers read zero and ignore writes
// - simultaneous lt errors set several detect bits together
module secm_monitor (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire secm_pkg::secm_lt_evt_s lt_evt_i,
  input wire secm_pkg::secm_tx_evt_s tx_evt_i,
  input wire logic power_down_i,
  input wire logic [3:0] lut_port_i,
  output logic err_report_o,
  output logic pw_req_o,
  output logic [15:0] pw_dest_o,
  output logic [3:0] pw_port_o
);
  import secm_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // lowest set bit wins so the encoded type is deterministic
  function automatic logic [4:0] first_err(input logic [31:0] bits);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (bits[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  secm_bus_e bus_state_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  logic [31:0] rd_value;
  logic wr_commit;
  logic [31:0] wr_word;

  logic [31:0] lt_detect_reg, lt_enable_reg, lt_addr_reg, lt_devid_reg, lt_ctrl_reg;
  logic [15:0] pw_target_reg;
  logic [31:0] port_detect_reg, rate_enable_reg, attr_reg;
  logic [31:0] capt_reg [CAPT_WORDS];
  logic [7:0] rate_reg, thresh_reg;
  logic debug_reg;

  function automatic logic hit(input logic [7:0] ofs);
    return avs_address_i == ofs;
  endfunction

  // writes land at the edge where waitrequest is seen low; powered down drops them
  assign wr_commit = (bus_state_reg == SECM_BUS_ACK) && avs_write_i && !power_down_i;

  always_comb begin
    rd_value = ZERO_WORD;
    wr_word = ZERO_WORD;
    case (avs_address_i)
      OFS_LT_DETECT: rd_value = lt_detect_reg;
      OFS_LT_ENABLE: rd_value = lt_enable_reg;
      OFS_LT_ADDR: rd_value = lt_addr_reg;
      OFS_LT_DEVID: rd_value = lt_devid_reg;
      OFS_LT_CTRL: rd_value = lt_ctrl_reg;
      OFS_PW_TARGET: rd_value = {16'h0000, pw_target_reg};
      OFS_PORT_DETECT: rd_value = port_detect_reg;
      OFS_RATE_ENABLE: rd_value = rate_enable_reg;
      OFS_CAPT_ATTR: rd_value = attr_reg;
      OFS_CAPT0: rd_value = capt_reg[0];
      OFS_CAPT1: rd_value = capt_reg[1];
      OFS_CAPT2: rd_value = capt_reg[2];
      OFS_CAPT3: rd_value = capt_reg[3];
      OFS_ERR_RATE: rd_value = {24'h000000, rate_reg};
      OFS_THRESHOLD: rd_value = {24'h000000, thresh_reg};
      OFS_DEBUG_CTRL: rd_value = {31'h00000000, debug_reg};
      default: rd_value = ZERO_WORD;
    endcase
    if (power_down_i) begin
      rd_value = ZERO_WORD;
    end
    wr_word = merge_be(rd_value, avs_writedata_i, avs_byteenable_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bus_state_reg <= SECM_BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= ZERO_WORD;
    end else begin
      case (bus_state_reg)
        SECM_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state_reg <= SECM_BUS_ACK;
            wait_reg <= 1'b0;
            rdata_reg <= avs_read_i ? rd_value : ZERO_WORD;
          end
        end
        SECM_BUS_ACK: begin
          bus_state_reg <= SECM_BUS_IDLE;
          wait_reg <= 1'b1;
        end
        default: begin
          bus_state_reg <= SECM_BUS_IDLE;
          wait_reg <= 1'b1;
        end
      endcase
    end
  end
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  // ----------------------------------------------------------------
  // logical/transport capture
  // ----------------------------------------------------------------
  logic lt_accept, lt_locked, lt_log, lt_take_ids;
  assign lt_accept = lt_evt_i.valid && (lt_evt_i.hop_count == HOP_ZERO)
                     && (lt_evt_i.kind != SECM_PKT_OTHER);
  assign lt_locked = |(lt_detect_reg & lt_enable_reg);
  assign lt_log = lt_accept && !lt_locked && |(lt_evt_i.err_bits & lt_enable_reg);
  // well formed requests that fail leave the id captures alone
  assign lt_take_ids = lt_log
                       && !(lt_evt_i.kind == SECM_PKT_MREQ && lt_evt_i.well_formed);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lt_detect_reg <= ZERO_WORD;
    end else begin
      // hardware set wins over a software write in the same cycle
      lt_detect_reg <= (wr_commit && hit(OFS_LT_DETECT) ? wr_word : lt_detect_reg)
                       | (lt_accept && !lt_locked ? lt_evt_i.err_bits : ZERO_WORD);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lt_enable_reg <= ZERO_WORD;
      pw_target_reg <= PW_TARGET_RESET;
    end else if (wr_commit) begin
      if (hit(OFS_LT_ENABLE)) begin
        lt_enable_reg <= wr_word;
      end
      if (hit(OFS_PW_TARGET)) begin
        pw_target_reg <= wr_word[15:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lt_addr_reg <= ZERO_WORD;
      lt_devid_reg <= ZERO_WORD;
      lt_ctrl_reg <= ZERO_WORD;
    end else if (lt_take_ids) begin
      // address position is taken as-is, even for invalid tt or reserved fields
      lt_addr_reg <= lt_evt_i.addr_field;
      lt_devid_reg <= lt_evt_i.tt_bad ? {16'h0000, lt_evt_i.hdr_bytes[39:24]}
                                      : lt_evt_i.devid_field;
      lt_ctrl_reg <= ZERO_WORD | (32'(lt_evt_i.ftype) << CTRL_FTYPE_LSB)
                     | (32'(lt_evt_i.ttype) << CTRL_TTYPE_LSB);
    end else if (wr_commit) begin
      if (hit(OFS_LT_ADDR)) begin
        lt_addr_reg <= wr_word;
      end
      if (hit(OFS_LT_DEVID)) begin
        lt_devid_reg <= wr_word;
      end
      if (hit(OFS_LT_CTRL)) begin
        lt_ctrl_reg <= wr_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // port transmission errors and capture
  // ----------------------------------------------------------------
  logic [31:0] tx_enabled;
  logic capt_take, sw_bump;
  assign tx_enabled = tx_evt_i.err_bits & rate_enable_reg;
  assign capt_take = |tx_enabled && !attr_reg[ATTR_VALID_BIT] && !debug_reg;
  assign sw_bump = wr_commit && hit(OFS_PORT_DETECT) && (wr_word != ZERO_WORD)
                   && |(wr_word & rate_enable_reg);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      port_detect_reg <= ZERO_WORD;
      rate_enable_reg <= ZERO_WORD;
      debug_reg <= 1'b0;
    end else begin
      port_detect_reg <= (wr_commit && hit(OFS_PORT_DETECT) ? wr_word : port_detect_reg)
                         | tx_evt_i.err_bits;
      if (wr_commit && hit(OFS_RATE_ENABLE)) begin
        rate_enable_reg <= wr_word;
      end
      if (wr_commit && hit(OFS_DEBUG_CTRL)) begin
        debug_reg <= wr_word[DEBUG_MODE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      attr_reg <= ZERO_WORD;
    end else if (capt_take) begin
      attr_reg <= ZERO_WORD | (32'(tx_evt_i.is_symbol) << ATTR_INFO_BIT)
                  | (32'(first_err(tx_enabled)) << ATTR_TYPE_LSB)
                  | (32'h0000_0001 << ATTR_VALID_BIT);
    end else if (wr_commit && hit(OFS_CAPT_ATTR)) begin
      if (debug_reg || !attr_reg[ATTR_VALID_BIT]) begin
        attr_reg <= wr_word;
      end else begin
        attr_reg[ATTR_VALID_BIT] <= wr_word[ATTR_VALID_BIT];
      end
    end
  end

  // software loads test data only while valid is clear (or in debug)
  genvar gi;
  generate
    for (gi = 0; gi < CAPT_WORDS; gi++) begin : g_capt
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          capt_reg[gi] <= ZERO_WORD;
        end else if (capt_take) begin
          capt_reg[gi] <= tx_evt_i.capt_words[gi*32 +: 32];
        end else if (wr_commit && hit(8'(OFS_CAPT0 + 8'(gi*4)))
                     && (debug_reg || !attr_reg[ATTR_VALID_BIT])) begin
          capt_reg[gi] <= wr_word;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // error rate counter, threshold and reporting
  // ----------------------------------------------------------------
  logic bump;
  logic [7:0] rate_next;
  assign bump = |tx_enabled || sw_bump;
  assign rate_next = (bump && rate_reg != RATE_MAX) ? rate_reg + RATE_ONE : rate_reg;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rate_reg <= 8'h00;
      thresh_reg <= THRESH_RESET;
    end else begin
      if (wr_commit && hit(OFS_ERR_RATE)) begin
        rate_reg <= wr_word[7:0];
      end else begin
        rate_reg <= rate_next;
      end
      if (wr_commit && hit(OFS_THRESHOLD)) begin
        thresh_reg <= wr_word[7:0];
      end
    end
  end

  // report once on the step that reaches a nonzero threshold
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      err_report_o <= 1'b0;
      pw_req_o <= 1'b0;
      pw_dest_o <= PW_TARGET_RESET;
      pw_port_o <= 4'h0;
    end else begin
      err_report_o <= 1'b0;
      pw_req_o <= 1'b0;
      if (!(wr_commit && hit(OFS_ERR_RATE)) && thresh_reg != THRESH_RESET
          && rate_reg != thresh_reg && rate_next == thresh_reg) begin
        err_report_o <= 1'b1;
        pw_req_o <= 1'b1;
        pw_dest_o <= pw_target_reg;
        pw_port_o <= lut_port_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_req_taken;
    (avs_read_i || avs_write_i) && wait_reg;
  endsequence
  sequence s_ack;
    !wait_reg ##1 wait_reg;
  endsequence

  bus_answer_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_req_taken |=> s_ack) else $error("bus answer not one cycle wide");
  pd_read_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (s_req_taken ##0 (avs_read_i && power_down_i)) |=> avs_readdata_o == ZERO_WORD)
    else $error("powered down read not zero");
  lt_freeze_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (lt_locked && !wr_commit) |=> $stable(lt_addr_reg) && $stable(lt_ctrl_reg))
    else $error("lt capture changed while locked");
  hop_filter_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (lt_evt_i.hop_count != HOP_ZERO && !wr_commit) |=> $stable(lt_detect_reg))
    else $error("nonzero hop logged");
  wellformed_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (lt_evt_i.kind == SECM_PKT_MREQ && lt_evt_i.well_formed && !wr_commit)
    |=> $stable(lt_devid_reg)) else $error("devid updated on good request");
  capt_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (attr_reg[ATTR_VALID_BIT] && !debug_reg) |=> $stable(capt_reg[0]))
    else $error("capture overwritten while valid");
  attr_lock_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (attr_reg[ATTR_VALID_BIT] && !debug_reg)
    |=> attr_reg[31:1] == $past(attr_reg[31:1]))
    else $error("locked attribute field changed");
  rate_step_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (|tx_enabled && !wr_commit && rate_reg < RATE_MAX) |=> rate_reg == $past(rate_reg) + 8'h01)
    else $error("rate counter did not step");
  report_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    err_report_o |-> pw_req_o && rate_reg == thresh_reg ##1 !err_report_o)
    else $error("report not tied to threshold");
endmodule

// *** tb/secm_link_partner.sv ***
/*
  secm_link_partner: far-side source of packet-checker and port
  transmission error events for the error monitor.
  assumes the caller lets each task return before calling the next.
*/
`timescale 1ns/10ps
module secm_link_partner (
  input wire logic core_clk_i,
  output secm_pkg::secm_lt_evt_s lt_evt_o,
  output secm_pkg::secm_tx_evt_s tx_evt_o
);
  import secm_pkg::*;
  // idle fields start as all ones rather than zero, so a stray sample cannot pass as a match
  initial begin
    lt_evt_o = '1;
    lt_evt_o.valid = 1'b0;
    tx_evt_o = '1;
    tx_evt_o.err_bits = '0;
  end
  // one-cycle event, then the inverse of what was sent while idle
  task automatic send_lt(input secm_lt_evt_s e);
    secm_lt_evt_s r;
    r = ~e;
    r.valid = 1'b0;
    @(posedge core_clk_i);
    lt_evt_o <= e;
    @(posedge core_clk_i);
    lt_evt_o <= r;
  endtask
  task automatic send_tx(input secm_tx_evt_s e);
    secm_tx_evt_s r;
    r = ~e;
    r.err_bits = '0;
    @(posedge core_clk_i);
    tx_evt_o <= e;
    @(posedge core_clk_i);
    tx_evt_o <= r;
  endtask
endmodule

// *** tb/tb_top.sv ***
/*
  tb_top: self-checking bench for secm_monitor with an avalon-mm master.
  assumes the link partner model in secm_link_partner.sv.
*/
`timescale 1ns/10ps
module tb_top;
  import secm_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, err_report_o, pw_req_o;
  logic power_down_i = 1'b0;
  logic [3:0] lut_port_i = 4'h0;
  logic [3:0] pw_port_o, lp;
  logic [15:0] pw_dest_o, pw;
  secm_lt_evt_s lt_evt_i, ev;
  secm_tx_evt_s tx_evt_i, tx;
  logic [31:0] q_d, c0, dv;
  int errors = 0;
  int n_tests = 0;
  int n_rep = 0;
  int n_pw = 0;
  int rate_m = 0;
  always #20 core_clk_i = ~core_clk_i;
  secm_monitor secm_monitor_inst (.core_clk_i, .reset_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .lt_evt_i, .tx_evt_i, .power_down_i, .lut_port_i, .err_report_o, .pw_req_o,
    .pw_dest_o, .pw_port_o);
  secm_link_partner secm_link_partner_inst (.core_clk_i, .lt_evt_o(lt_evt_i),
    .tx_evt_o(tx_evt_i));
  always @(posedge core_clk_i) begin
    if (err_report_o === 1'b1) n_rep++;
    if (pw_req_o === 1'b1) n_pw++;
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    // no local limit: a slave that never answers is caught by the hang guard
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    check(q, exp);
  endtask
  function automatic secm_lt_evt_s mk_lt(input secm_pkt_e k, input logic [7:0] hop,
                                         input logic wf, input logic [31:0] eb);
    return '{1'b1, k, hop, ~wf, wf, eb, $urandom, $urandom, {$urandom, $urandom},
             4'h8, 4'($urandom)};
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(76));
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    rd(OFS_CAPT_ATTR, ZERO_WORD);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, ZERO_WORD);
    // rate counting and threshold report
    pw = 16'($urandom);
    lp = 4'($urandom);
    lut_port_i <= lp;
    wr(OFS_PW_TARGET, {16'h0000, pw});
    bus(1'b1, OFS_THRESHOLD, 32'hFFFF_FF03, 4'h1, q_d);
    wr(OFS_RATE_ENABLE, 32'h0000_0001);
    wr(OFS_PORT_DETECT, 32'h0000_0002);
    rd(OFS_ERR_RATE, 32'(rate_m));
    repeat (3) wr(OFS_PORT_DETECT, 32'h0000_0001);
    rate_m += 3;
    rd(OFS_ERR_RATE, 32'(rate_m));
    check(32'(n_rep), 32'h1);
    check(32'(n_pw), 32'h1);
    check({16'h0000, pw_dest_o}, {16'h0000, pw});
    check({28'h0, pw_port_o}, {28'h0, lp});
    // transmission error capture, lock and software access
    wr(OFS_RATE_ENABLE, 32'h0000_000C);
    wr(OFS_PORT_DETECT, ZERO_WORD);
    tx = '{32'h0000_001C, 1'b1, {$urandom, $urandom, $urandom, $urandom}};
    c0 = tx.capt_words[31:0];
    secm_link_partner_inst.send_tx(tx);
    rate_m++;
    rd(OFS_CAPT_ATTR, 32'h4200_0001);
    rd(OFS_CAPT0, c0);
    rd(OFS_CAPT3, tx.capt_words[127:96]);
    rd(OFS_ERR_RATE, 32'(rate_m));
    rd(OFS_PORT_DETECT, 32'h0000_001C);
    tx = '{32'h0000_0004, 1'b0, {$urandom, $urandom, $urandom, $urandom}};
    secm_link_partner_inst.send_tx(tx);
    rate_m++;
    rd(OFS_CAPT0, c0);
    wr(OFS_CAPT0, 32'hA5A5_5A5A);
    rd(OFS_CAPT0, c0);
    wr(OFS_CAPT_ATTR, 32'h1F00_0001);
    rd(OFS_CAPT_ATTR, 32'h4200_0001);
    wr(OFS_CAPT_ATTR, ZERO_WORD);
    rd(OFS_CAPT_ATTR, 32'h4200_0000);
    wr(OFS_CAPT0, 32'hA5A5_5A5A);
    rd(OFS_CAPT0, 32'hA5A5_5A5A);
    // debug packet composition
    wr(OFS_DEBUG_CTRL, 32'h0000_0001);
    wr(OFS_CAPT_ATTR, 32'h4500_0001);
    rd(OFS_CAPT_ATTR, 32'h4500_0001);
    c0 = $urandom;
    wr(OFS_CAPT0, c0);
    rd(OFS_CAPT0, c0);
    secm_link_partner_inst.send_tx(tx);
    rate_m++;
    rd(OFS_CAPT0, c0);
    rd(OFS_ERR_RATE, 32'(rate_m));
    wr(OFS_DEBUG_CTRL, ZERO_WORD);
    // logical/transport capture, every maintenance kind
    wr(OFS_LT_ENABLE, 32'h0000_0001);
    secm_link_partner_inst.send_lt(mk_lt(SECM_PKT_MREQ, 8'h01, 1'b0, 32'h1));
    secm_link_partner_inst.send_lt(mk_lt(SECM_PKT_OTHER, HOP_ZERO, 1'b0, 32'h1));
    rd(OFS_LT_DETECT, ZERO_WORD);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_LT_DETECT, ZERO_WORD);
      ev = mk_lt(secm_pkt_e'(k), HOP_ZERO, 1'b0, 32'h0000_0005);
      // one pass keeps a valid tt code so the plain source id path is covered too
      ev.tt_bad = (k != 1);
      dv = ev.tt_bad ? {16'h0000, ev.hdr_bytes[39:24]} : ev.devid_field;
      secm_link_partner_inst.send_lt(ev);
      rd(OFS_LT_DETECT, 32'h0000_0005);
      rd(OFS_LT_DEVID, dv);
      rd(OFS_LT_CTRL, {ev.ftype, ev.ttype, 24'h000000});
      if (k == 0) rd(OFS_LT_ADDR, ev.addr_field);
      secm_link_partner_inst.send_lt(mk_lt(SECM_PKT_MREQ, HOP_ZERO, 1'b0, 32'h1));
      rd(OFS_LT_DEVID, dv);
      rd(OFS_LT_DETECT, 32'h0000_0005);
      wr(OFS_LT_CTRL, ZERO_WORD);
      rd(OFS_LT_CTRL, ZERO_WORD);
    end
    wr(OFS_LT_DETECT, ZERO_WORD);
    secm_link_partner_inst.send_lt(mk_lt(SECM_PKT_MREQ, HOP_ZERO, 1'b1, 32'h1));
    rd(OFS_LT_DETECT, 32'h0000_0001);
    rd(OFS_LT_DEVID, dv);
    rd(OFS_LT_CTRL, ZERO_WORD);
    // powered-down port
    power_down_i <= 1'b1;
    rd(OFS_THRESHOLD, ZERO_WORD);
    wr(OFS_THRESHOLD, 32'h0000_0007);
    power_down_i <= 1'b0;
    rd(OFS_THRESHOLD, 32'h0000_0003);
    print_verdict();
  end
endmodule
